// ===== design/imd_pkg.sv
// shared constants, opcodes, step counts and decode helpers for the multiply/divide sequencer
package imd_pkg;
    localparam int W = 48;
    localparam int CW = 6;
    localparam logic [47:0] WORD_RST = 48'h000000000000;
    localparam logic [47:0] COEF_MASK = 48'h000FFFFFFFFF;
    localparam logic [5:0] OP_MUL_INT = 6'h14;
    localparam logic [5:0] OP_DIV_INT = 6'h15;
    localparam logic [5:0] OP_MUL_FRAC = 6'h16;
    localparam logic [5:0] OP_DIV_FRAC = 6'h17;
    localparam logic [5:0] OP_MUL_FLT = 6'h1A;
    localparam logic [5:0] OP_DIV_FLT = 6'h1B;
    localparam logic [5:0] STEPS_MUL_INT = 6'h30;
    localparam logic [5:0] STEPS_MUL_FRAC = 6'h2F;
    localparam logic [5:0] STEPS_FLT = 6'h24;
    localparam logic [5:0] STEPS_DIV_FIX = 6'h30;
    localparam logic [5:0] CNT_RST = 6'h00;

    typedef enum logic [2:0] {PH_IDLE, PH_INIT, PH_XFER, PH_LOOP, PH_POST, PH_FINAL, PH_DONE}
        imd_phase_t;

    function automatic logic imd_op_ok(input logic [5:0] op);
        return op inside {OP_MUL_INT, OP_DIV_INT, OP_MUL_FRAC, OP_DIV_FRAC, OP_MUL_FLT, OP_DIV_FLT};
    endfunction

    function automatic logic imd_is_div(input logic [5:0] op);
        return op inside {OP_DIV_INT, OP_DIV_FRAC, OP_DIV_FLT};
    endfunction

    function automatic logic imd_is_flt(input logic [5:0] op);
        return op inside {OP_MUL_FLT, OP_DIV_FLT};
    endfunction

    function automatic logic [5:0] imd_steps(input logic [5:0] op);
        unique case (op)
            OP_MUL_INT: return STEPS_MUL_INT;
            OP_MUL_FRAC: return STEPS_MUL_FRAC;
            OP_MUL_FLT, OP_DIV_FLT: return STEPS_FLT;
            default: return STEPS_DIV_FIX;
        endcase
    endfunction
endpackage

// ===== design/imd_core_if.sv
// signals between the sequencer and its step counter and step datapath
`timescale 1ns/10ps
interface imd_core_if;
    logic stage_we;
    logic [5:0] stage_val;
    logic xfer;
    logic dec;
    logic cnt_zero;
    logic [5:0] cnt;
    logic div_mode;
    logic [47:0] a_in;
    logic [47:0] q_in;
    logic [47:0] x_in;
    logic [47:0] a_out;
    logic [47:0] q_out;
    logic departing;
    modport ctl(output stage_we, stage_val, xfer, dec, div_mode, a_in, q_in, x_in,
        input cnt_zero, cnt, a_out, q_out, departing);
    modport counter(input stage_we, stage_val, xfer, dec, output cnt_zero, cnt);
    modport alu(input div_mode, a_in, q_in, x_in, output a_out, q_out, departing);
endinterface

// ===== design/imd_step_count.sv
// step count staging register and down counter
`timescale 1ns/10ps
module imd_step_count
    import imd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    imd_core_if.counter c
);
    typedef struct packed {
        logic [5:0] stage;
        logic [5:0] count;
    } imd_cnt_state_t;

    imd_cnt_state_t st_ff;
    imd_cnt_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (c.stage_we) begin
            nxt_st.stage = c.stage_val;
        end
        if (c.xfer) begin
            nxt_st.count = st_ff.stage;
        end else if (c.dec && st_ff.count != CNT_RST) begin
            nxt_st.count = st_ff.count - 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '{stage: CNT_RST, count: CNT_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign c.cnt = st_ff.count;
    assign c.cnt_zero = (st_ff.count == CNT_RST);
endmodule // imd_step_count

// ===== design/imd_step_alu.sv
// one add-and-shift-right or shift-left-and-subtract step on the double register
`timescale 1ns/10ps
module imd_step_alu
    import imd_pkg::*;
(
    imd_core_if.alu s
);
    logic [48:0] sum;
    logic [96:0] mul_sh;
    logic [47:0] sh_a;
    logic [47:0] sh_q;
    logic fits;

    always_comb begin
        // long loop adds the operand, short loop adds nothing
        sum = {1'b0, s.a_in} + {1'b0, (s.q_in[0] ? s.x_in : WORD_RST)};
        mul_sh = {sum, s.q_in} >> 1;
        // circular left shift; the wrapped bit in the low stage is replaced by the quotient bit
        sh_a = {s.a_in[46:0], s.q_in[47]};
        sh_q = {s.q_in[46:0], s.a_in[47]};
        fits = ({s.a_in[47], sh_a} >= {1'b0, s.x_in});
        if (s.div_mode) begin
            s.a_out = fits ? 48'(sh_a - s.x_in) : sh_a;
            s.q_out = {sh_q[47:1], fits};
            s.departing = s.a_in[47];
        end else begin
            s.a_out = mul_sh[95:48];
            s.q_out = mul_sh[47:0];
            s.departing = s.q_in[0];
        end
    end
endmodule // imd_step_alu

// ===== design/imd_iter_seq.sv
// iterative multiply and divide sequencer, top level
`timescale 1ns/10ps
module imd_iter_seq
    import imd_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic START,
    input wire logic [5:0] OP_CODE,
    input wire logic [47:0] ACC_IN,
    input wire logic [47:0] AUX_IN,
    input wire logic [47:0] MEM_DATA,
    input wire logic FAULT_CLR,
    output logic BUSY,
    output logic DONE,
    output logic [47:0] ACC_OUT,
    output logic [47:0] AUX_OUT,
    output logic RESULT_NEGATIVE,
    output logic QUOT_OVERFLOW
);
    typedef struct packed {
        imd_phase_t ph;
        logic [5:0] op;
        logic [47:0] a;
        logic [47:0] q;
        logic [47:0] x;
        logic result_negative_flag;
        logic remainder_polarity_flag;
        logic quotient_overflow_flag;
        logic path;
    } imd_state_t;

    imd_state_t st_ff;
    imd_state_t nxt_st;
    imd_core_if core();

    imd_step_count u_count (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .c(core.counter)
    );

    imd_step_alu u_alu (
        .s(core.alu)
    );

    logic is_div;
    logic is_flt;
    logic [47:0] hi;
    logic [47:0] lo;
    logic [47:0] xm;
    logic [95:0] prod;

    assign is_div = imd_is_div(st_ff.op);
    assign is_flt = imd_is_flt(st_ff.op);
    assign core.div_mode = is_div;
    assign core.a_in = st_ff.a;
    assign core.q_in = st_ff.q;
    assign core.x_in = st_ff.x;

    always_comb begin
        nxt_st = st_ff;
        core.stage_we = 1'b0;
        core.stage_val = imd_steps(st_ff.op);
        core.xfer = 1'b0;
        core.dec = 1'b0;
        hi = st_ff.a;
        lo = st_ff.q;
        xm = st_ff.x[47] ? ~st_ff.x : st_ff.x;
        prod = {st_ff.a, st_ff.q};
        if (FAULT_CLR) begin
            nxt_st.quotient_overflow_flag = 1'b0;
        end
        unique case (st_ff.ph)
            PH_IDLE: begin
                // a start while busy is ignored; the controller waits for done
                if (START && imd_op_ok(OP_CODE)) begin
                    nxt_st.op = OP_CODE;
                    nxt_st.a = ACC_IN;
                    nxt_st.q = AUX_IN;
                    nxt_st.x = MEM_DATA;
                    nxt_st.ph = PH_INIT;
                end
            end
            PH_INIT: begin
                if (is_flt) begin
                    xm = xm & COEF_MASK;
                end
                nxt_st.x = xm;
                core.stage_we = 1'b1;
                if (is_div) begin
                    if (st_ff.op == OP_DIV_INT) begin
                        hi = st_ff.q;
                        lo = st_ff.a;
                    end
                    nxt_st.a = hi[47] ? ~hi : hi;
                    nxt_st.q = hi[47] ? ~lo : lo;
                    nxt_st.result_negative_flag = hi[47] ^ st_ff.x[47];
                    nxt_st.remainder_polarity_flag = hi[47];
                end else begin
                    lo = st_ff.a[47] ? ~st_ff.a : st_ff.a;
                    nxt_st.q = is_flt ? (lo & COEF_MASK) : lo;
                    nxt_st.a = WORD_RST;
                    nxt_st.result_negative_flag = st_ff.a[47] ^ st_ff.x[47];
                end
                nxt_st.ph = PH_XFER;
            end
            PH_XFER: begin
                core.xfer = 1'b1;
                nxt_st.ph = PH_LOOP;
            end
            PH_LOOP: begin
                if (core.cnt_zero) begin
                    nxt_st.ph = is_div ? PH_POST : PH_FINAL;
                end else begin
                    core.dec = 1'b1;
                    nxt_st.a = core.a_out;
                    nxt_st.q = core.q_out;
                    nxt_st.path = core.departing;
                end
            end
            PH_POST: begin
                // set overrides a clear arriving in the same cycle
                if (st_ff.q[47]) begin
                    nxt_st.quotient_overflow_flag = 1'b1;
                end
                nxt_st.a = st_ff.q;
                nxt_st.q = st_ff.a;
                nxt_st.ph = PH_FINAL;
            end
            PH_FINAL: begin
                if (is_div) begin
                    nxt_st.a = st_ff.result_negative_flag ? ~st_ff.a : st_ff.a;
                    nxt_st.q = st_ff.remainder_polarity_flag ? ~st_ff.q : st_ff.q;
                end else begin
                    // the step count has already placed the binary point
                    if (is_flt && st_ff.q[47]) begin
                        prod[95:48] = 48'(st_ff.a + 48'h000000000001);
                    end
                    if (st_ff.result_negative_flag) begin
                        prod = ~prod;
                    end
                    if (st_ff.op == OP_MUL_INT) begin
                        prod = {prod[47:0], prod[95:48]};
                    end
                    nxt_st.a = prod[95:48];
                    nxt_st.q = prod[47:0];
                end
                nxt_st.ph = PH_DONE;
            end
            PH_DONE: begin
                nxt_st.ph = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_ff <= '{ph: PH_IDLE, op: OP_MUL_INT, a: WORD_RST, q: WORD_RST, x: WORD_RST,
                result_negative_flag: 1'b0, remainder_polarity_flag: 1'b0,
                quotient_overflow_flag: 1'b0, path: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign BUSY = (st_ff.ph != PH_IDLE);
    assign DONE = (st_ff.ph == PH_DONE);
    assign ACC_OUT = st_ff.a;
    assign AUX_OUT = st_ff.q;
    assign RESULT_NEGATIVE = st_ff.result_negative_flag;
    assign QUOT_OVERFLOW = st_ff.quotient_overflow_flag;

    // counts loop steps so the step total can be checked at loop exit
    logic [5:0] loop_cyc_ff;
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || st_ff.ph == PH_XFER) begin
            loop_cyc_ff <= CNT_RST;
        end else if (core.dec) begin
            loop_cyc_ff <= loop_cyc_ff + 6'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    a_mul_sign_rec: assert property (
        st_ff.ph == PH_INIT && !is_div |=> !st_ff.q[47]
            && st_ff.result_negative_flag == $past(st_ff.a[47] ^ st_ff.x[47]))
        else $error("multiply sign record wrong");
    a_count_xfer: assert property (
        st_ff.ph == PH_XFER |=> core.cnt == imd_steps(st_ff.op) && st_ff.ph == PH_LOOP)
        else $error("step count not transferred");
    a_loop_length: assert property (
        st_ff.ph == PH_LOOP && core.cnt_zero |-> loop_cyc_ff == imd_steps(st_ff.op))
        else $error("wrong number of steps");
    a_path_hold: assert property (
        st_ff.ph == PH_LOOP && !core.cnt_zero && !is_div |=> st_ff.path == $past(st_ff.q[0]))
        else $error("departing bit not held");
    a_short_loop: assert property (
        st_ff.ph == PH_LOOP && !core.cnt_zero && !is_div && !st_ff.q[0]
            |=> {st_ff.a, st_ff.q} == {1'b0, $past(st_ff.a), $past(st_ff.q[47:1])})
        else $error("short loop did more than shift");
    a_mul_final: assert property (
        st_ff.ph == PH_FINAL && st_ff.op == OP_MUL_FRAC |=> {st_ff.a, st_ff.q} ==
            ($past(st_ff.result_negative_flag) ? ~$past({st_ff.a, st_ff.q})
            : $past({st_ff.a, st_ff.q})))
        else $error("product sign correction wrong");
    a_int_swap: assert property (
        st_ff.ph == PH_FINAL && st_ff.op == OP_MUL_INT
            |=> st_ff.a == ($past(st_ff.result_negative_flag) ? ~$past(st_ff.q) : $past(st_ff.q))
            && st_ff.q == ($past(st_ff.result_negative_flag) ? ~$past(st_ff.a) : $past(st_ff.a)))
        else $error("integer product halves not swapped");
    a_div_swap: assert property (
        st_ff.ph == PH_INIT && st_ff.op == OP_DIV_INT
            |=> st_ff.a == ($past(st_ff.q[47]) ? ~$past(st_ff.q) : $past(st_ff.q))
            && st_ff.q == ($past(st_ff.q[47]) ? ~$past(st_ff.a) : $past(st_ff.a)))
        else $error("integer dividend halves not swapped");
    // an overflowing dividend starts at or above the divisor, so only a fitting one is held to it
    a_div_rem: assert property (
        st_ff.ph == PH_LOOP && !core.cnt_zero && is_div && st_ff.a < st_ff.x
            |=> st_ff.a < st_ff.x)
        else $error("partial remainder not below divisor");
    a_div_move: assert property (
        st_ff.ph == PH_POST |=> st_ff.a == $past(st_ff.q) && st_ff.q == $past(st_ff.a)
            && ($past(st_ff.q[47]) -> st_ff.quotient_overflow_flag))
        else $error("quotient move or overflow wrong");
    a_div_final: assert property (
        st_ff.ph == PH_FINAL && is_div |=> st_ff.q == ($past(st_ff.remainder_polarity_flag)
            ? ~$past(st_ff.q) : $past(st_ff.q)) ##1 st_ff.ph == PH_IDLE)
        else $error("divide sign correction wrong");

    c_mul_int: cover property (DONE && st_ff.op == OP_MUL_INT && st_ff.result_negative_flag);
    c_div_fault: cover property (st_ff.ph == PH_POST && st_ff.q[47]);
    c_long_loop: cover property (core.dec && !is_div && st_ff.q[0]);
    c_flt_round: cover property (st_ff.ph == PH_FINAL && st_ff.op == OP_MUL_FLT && st_ff.q[47]);
endmodule // imd_iter_seq

// ===== tb/imd_ctl_model.sv
// control section model: launches one instruction and waits for its completion
`timescale 1ns/10ps
module imd_ctl_model
    import imd_pkg::*;
(
    input wire logic clk,
    input wire logic busy,
    input wire logic done,
    output logic start,
    output logic [5:0] op_code,
    output logic [47:0] acc_in,
    output logic [47:0] aux_in,
    output logic [47:0] mem_data
);
    initial begin
        start = 1'b0;
        op_code = 6'h00;
        acc_in = 48'h000000000000;
        aux_in = 48'h000000000000;
        mem_data = 48'h000000000000;
    end

    // operands are inverted once taken, so a late sample of them cannot pass unseen
    task automatic run(input logic [5:0] op, input logic [47:0] a, input logic [47:0] q,
                       input logic [47:0] x, output int cycles);
        cycles = 0;
        @(posedge clk);
        start <= 1'b1;
        op_code <= op;
        acc_in <= a;
        aux_in <= q;
        mem_data <= x;
        @(posedge clk);
        start <= 1'b0;
        op_code <= ~op;
        acc_in <= ~a;
        aux_in <= ~q;
        mem_data <= ~x;
        while (cycles < 200) begin
            @(posedge clk);
            #1;
            cycles++;
            if (done === 1'b1) begin
                break;
            end
        end
    endtask

    task automatic poke(input logic [5:0] op, output logic busy_seen);
        @(posedge clk);
        start <= 1'b1;
        op_code <= op;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        busy_seen = busy;
    endtask
endmodule // imd_ctl_model

// ===== tb/iterative_multiply_divide_tb.sv
// self-checking testbench of the multiply/divide sequencer
`timescale 1ns/10ps
module iterative_multiply_divide_tb
    import imd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic fault_clr = 1'b0;
    logic start;
    logic [5:0] op_code;
    logic [47:0] acc_in;
    logic [47:0] aux_in;
    logic [47:0] mem_data;
    logic busy;
    logic done;
    logic [47:0] acc_out;
    logic [47:0] aux_out;
    logic res_neg;
    logic quot_ovf;
    int n_fail = 0;
    int checked = 0;

    always #20 clk_sys = ~clk_sys;

    imd_iter_seq dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .START(start), .OP_CODE(op_code),
        .ACC_IN(acc_in), .AUX_IN(aux_in), .MEM_DATA(mem_data), .FAULT_CLR(fault_clr),
        .BUSY(busy), .DONE(done), .ACC_OUT(acc_out), .AUX_OUT(aux_out),
        .RESULT_NEGATIVE(res_neg), .QUOT_OVERFLOW(quot_ovf));

    imd_ctl_model ctl (.clk(clk_sys), .busy(busy), .done(done), .start(start),
        .op_code(op_code), .acc_in(acc_in), .aux_in(aux_in), .mem_data(mem_data));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // runs one instruction and checks its fixed latency
    task automatic go(input logic [5:0] op, input logic [47:0] a, input logic [47:0] q,
                      input logic [47:0] x, input int exp_cyc);
        int cyc;
        ctl.run(op, a, q, x, cyc);
        chk(48'(cyc), 48'(exp_cyc));
    endtask

    // a run is well under 2,500 cycles; this cuts a hang short
    initial begin
        #100us;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        logic [47:0] a1;
        logic [47:0] x1;
        logic [47:0] hi;
        logic [47:0] lo;
        logic [95:0] p;
        logic [95:0] d;
        logic [95:0] qt;
        logic [95:0] rm;
        logic b;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(acc_out, WORD_RST);
        chk({46'h0, busy, quot_ovf}, 48'h0);
        // integer multiply, negative multiplicand; stray auxiliary input must not leak
        a1 = 48'h123456789ABC;
        x1 = 48'h0FEDCBA98765;
        p = 96'(a1) * 96'(x1);
        // latency counts edges after the taking edge: steps + 4, one more for divide
        go(OP_MUL_INT, a1, 48'h5A5A5A5A5A5A, ~x1, 52);
        chk(acc_out, ~p[47:0]);
        chk(aux_out, ~p[95:48]);
        chk({47'h0, res_neg}, 48'h1);
        // fractional multiply, both negative, back to back
        a1 = 48'h600000000003;
        x1 = 48'h500000000005;
        p = (96'(a1) * 96'(x1)) << 1;
        go(OP_MUL_FRAC, ~a1, 48'hA5A5A5A5A5A5, ~x1, 51);
        chk(acc_out, p[95:48]);
        chk(aux_out, p[47:0]);
        chk({47'h0, res_neg}, 48'h0);
        // floating multiply: bits above the coefficient are ignored
        a1 = 48'h03F123456789;
        x1 = 48'h00ABCDEF0123;
        p = (96'(a1 & COEF_MASK) * 96'(x1 & COEF_MASK)) << 12;
        go(OP_MUL_FLT, a1, 48'h0, x1, 40);
        chk(acc_out, p[95:48] + 48'(p[47]));
        // integer divide, negative dividend arriving low half first
        hi = 48'h000000000012;
        lo = 48'h3456789ABCDE;
        x1 = 48'h000001234567;
        d = {hi, lo};
        qt = d / 96'(x1);
        rm = d % 96'(x1);
        go(OP_DIV_INT, ~lo, ~hi, x1, 53);
        chk(acc_out, ~qt[47:0]);
        chk(aux_out, ~rm[47:0]);
        chk({46'h0, res_neg, quot_ovf}, 48'h2);
        // fractional divide, negative divisor: remainder stays positive
        go(OP_DIV_FRAC, hi, lo, ~x1, 53);
        chk(acc_out, ~qt[47:0]);
        chk(aux_out, rm[47:0]);
        // dividend too large for the quotient register
        go(OP_DIV_FRAC, 48'h000000000005, 48'h0, 48'h000000000003, 53);
        chk({47'h0, quot_ovf}, 48'h1);
        // floating divide: 36 steps consume the double register down to bit 12
        go(OP_DIV_FLT, 48'h0, 48'h000ABCDEF000, 48'h0000000003E7, 41);
        chk(acc_out, 48'h000000ABCDEF / 48'h0000000003E7);
        chk(aux_out, 48'h000000ABCDEF % 48'h0000000003E7);
        chk({47'h0, quot_ovf}, 48'h1);
        @(posedge clk_sys);
        fault_clr <= 1'b1;
        @(posedge clk_sys);
        fault_clr <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({47'h0, quot_ovf}, 48'h0);
        // an unknown instruction code is ignored
        ctl.poke(6'h00, b);
        chk({47'h0, b}, 48'h0);
        tally_and_finish();
    end
endmodule // iterative_multiply_divide_tb
